/* hdl/uci_top.sv */
// Interrupt enable, priority and identification for one serial channel,
// with receive time-out timer and delayed transmit-empty indication.
// Assumes fifo levels, receive and fault pulses and the 16x baud tick
// come from logic on sys_clk; modem inputs are asynchronous pins.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////
// Contract
// - Time-out fires: data in fifo, no receive, no read for four chars.
// - Time-out counted in character times from baud ticks, stop bits in.
// - Without pending time-out, reads or new characters restart timer.
// - Receive buffer read clears a pending time-out and restarts timer.
// - Fifo on, enabled: empty transmit fifo signals code 02.
// - Empty indication delayed char minus stop when never two bytes.
// - First transmit interrupt after fifo enable change is immediate.
// - Priority: line status, receive data or time-out, transmit, modem.
// - Cleared enable bits give polled mode; no time-out or trigger.
// - All enables clear: identification and interrupt output suppressed.
// - Channel interrupt output is high while an enabled source pends.
// - Enable bits: 0 receive/time-out, 1 transmit, 2 line, 3 modem.
// - Enable register bits 7 to 4 always read zero.
// - Codes: 1 none, 6 line, 4 data, C time-out, 2 transmit, 0 modem.
// - Receive data pending until fill drops below trigger level; with fifos off, until fill is zero.
// - Any modem input change raises the modem status source.
// - Identification bit 0 low while pending, high when none.
// - Bit 3 zero without fifos; set with bit 2 on time-out.
// - Bits 5 and 4 zero; bits 7 and 6 set with fifo enabled.
// - Identification read clears transmit-empty only when reported.
// - Line faults raise top priority source; line status read clears.
module uci_top (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire uci_pkg::uci_req_s req,
  output logic            [7:0] rd_data,
  input  wire uci_pkg::uci_chan_s chan,
  input  wire logic             baud16_tick,
  input  wire logic       [3:0] modem_pins,
  output logic                  fifo_enable_setting,
  output logic                  transmit_holding_empty,
  output logic                  channel_interrupt_out
);

  // All state of the channel interrupt logic
  typedef struct packed {
    logic [3:0]       ien;
    logic             fifo_en;
    logic [3:0]       fmt;
    logic [7:0]       rdata;
    logic [9:0]       tmo_cnt;
    logic             tmo_pend;
    logic             ls_pend;
    logic             ms_pend;
    logic             txe_pend;
    uci_pkg::uci_tx_e tx_state;
    logic [7:0]       tx_cnt;
    logic             tx_multi;
    logic             tx_immed;
    logic [3:0]       mdm_s1;
    logic [3:0]       mdm_s2;
    logic [3:0]       mdm_s3;
  } uci_state_s;

  uci_state_s st_r;
  uci_state_s st_nxt;

  // Bits per character: start, data, parity and programmed stop bits
  function automatic logic [3:0] char_bits(input logic [3:0] fmt);
    logic [3:0] stop;
    stop = fmt[uci_pkg::FMT_STOP] ? 4'h2 : 4'h1;
    char_bits = uci_pkg::START_BITS + uci_pkg::MIN_WORD
              + {2'h0, fmt[1:0]} + {3'h0, fmt[uci_pkg::FMT_PAR]} + stop;
  endfunction : char_bits

  // Register port address decode
  function automatic logic hit(input uci_pkg::uci_req_s r,
                               input logic [2:0] ofs);
    hit = r.addr == ofs;
  endfunction : hit

  //////////////////////////////////////////////////////////////////////
  // Decode and derived timing

  logic       rxq_rd;
  logic       txq_wr;
  logic       iid_rd;
  logic [3:0] bits;
  logic [7:0] char_ticks;
  logic [9:0] tmo_limit;
  logic [7:0] tx_delay;

  assign rxq_rd = req.rd && hit(req, uci_pkg::OFS_DATA);
  assign txq_wr = req.wr && hit(req, uci_pkg::OFS_DATA);
  assign iid_rd = req.rd && hit(req, uci_pkg::OFS_IID);

  // Delay follows the programmed format, so it scales with baud rate
  assign bits       = char_bits(st_r.fmt);
  assign char_ticks = 8'({4'h0, bits} * uci_pkg::TICKS_PER_BIT);
  assign tmo_limit  = 10'({2'h0, char_ticks} * uci_pkg::TMO_CHARS);
  // Last stop bit is left out of the transmit empty delay
  assign tx_delay   = 8'(char_ticks - uci_pkg::TICKS_PER_BIT);

  //////////////////////////////////////////////////////////////////////
  // Source resolution, evaluated every clock from current state

  logic       p_ls;
  logic       p_rx;
  logic       p_tmo;
  logic       p_txe;
  logic       p_ms;
  logic       any_pend;
  logic [3:0] code;
  logic [7:0] iid_byte;
  logic       rx_has;

  assign rx_has = chan.rx_level != 5'h00;
  assign p_ls   = st_r.ien[uci_pkg::IEN_LS] && st_r.ls_pend;
  // Trigger level counts only with fifos on; plain mode needs one byte
  assign p_rx   = st_r.ien[uci_pkg::IEN_RX] && (st_r.fifo_en ?
                  chan.rx_level >= chan.rx_trigger : rx_has);
  // A time-out left over from fifo mode must not show in plain mode
  assign p_tmo  = st_r.ien[uci_pkg::IEN_RX] && st_r.fifo_en
                  && st_r.tmo_pend;
  assign p_txe  = st_r.ien[uci_pkg::IEN_TX] && st_r.txe_pend;
  assign p_ms   = st_r.ien[uci_pkg::IEN_MS] && st_r.ms_pend;
  assign any_pend = p_ls || p_rx || p_tmo || p_txe || p_ms;

  // Highest pending source wins
  always_comb begin
    if (p_ls) begin
      code = uci_pkg::IID_LINE;
    end else if (p_rx) begin
      code = uci_pkg::IID_RXD;
    end else if (p_tmo) begin
      code = uci_pkg::IID_TMO;
    end else if (p_txe) begin
      code = uci_pkg::IID_TXE;
    end else if (p_ms) begin
      code = uci_pkg::IID_MDM;
    end else begin
      code = uci_pkg::IID_NONE;
    end
  end

  // Fifo marker on top, bits 5 and 4 always zero
  assign iid_byte = {st_r.fifo_en ? uci_pkg::IID_FIFO : 2'h0,
                     2'h0, code};

  //////////////////////////////////////////////////////////////////////
  // Event detection

  logic mdm_change;
  logic tmo_set;
  logic txe_event;
  logic tx_to_empty;
  logic tx_go_delay;

  // Only the second and third synchroniser stages are compared
  assign mdm_change = st_r.mdm_s2 != st_r.mdm_s3;

  // Polled receiver never flags a time-out
  assign tmo_set = st_r.fifo_en && st_r.ien[uci_pkg::IEN_RX] && rx_has
                 && !st_r.tmo_pend && st_r.tmo_cnt >= tmo_limit;

  // Fifo ran empty: delay only if it never held two bytes at once
  assign tx_go_delay = st_r.tx_state == uci_pkg::TX_FILL
                    && chan.tx_level == 5'h00 && st_r.fifo_en
                    && !st_r.tx_multi && !st_r.tx_immed;
  assign tx_to_empty =
      (st_r.tx_state == uci_pkg::TX_FILL && chan.tx_level == 5'h00
       && !tx_go_delay)
   || (st_r.tx_state == uci_pkg::TX_DELAY && chan.tx_level == 5'h00
       && st_r.tx_cnt >= tx_delay);

  // Enabling the source while already empty also raises it
  assign txe_event = tx_to_empty
      || (st_r.tx_state == uci_pkg::TX_EMPTY && req.wr
          && hit(req, uci_pkg::OFS_IEN)
          && req.wdata[uci_pkg::IEN_TX] && !st_r.ien[uci_pkg::IEN_TX]);

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    // Modem pins pass two flops before the change detector
    st_nxt.mdm_s1 = modem_pins;
    st_nxt.mdm_s2 = st_r.mdm_s1;
    st_nxt.mdm_s3 = st_r.mdm_s2;

    // Register writes; upper enable bits never stored
    if (req.wr && hit(req, uci_pkg::OFS_IEN)) begin
      st_nxt.ien = req.wdata[3:0];
    end
    if (req.wr && hit(req, uci_pkg::OFS_IID)) begin
      st_nxt.fifo_en = req.wdata[uci_pkg::FIFO_EN];
      if (req.wdata[uci_pkg::FIFO_EN] != st_r.fifo_en) begin
        st_nxt.tx_immed = 1'b1;
      end
    end
    if (req.wr && hit(req, uci_pkg::OFS_CHAR_FMT)) begin
      st_nxt.fmt = req.wdata[3:0];
    end

    // Read data stand one cycle after the strobe; unmapped read zero
    st_nxt.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        uci_pkg::OFS_IEN:      st_nxt.rdata = {4'h0, st_r.ien};
        uci_pkg::OFS_IID:      st_nxt.rdata = iid_byte;
        uci_pkg::OFS_CHAR_FMT: st_nxt.rdata = {4'h0, st_r.fmt};
        default:               st_nxt.rdata = 8'h00;
      endcase
    end

    // Time-out timer restarts on activity while nothing is pending
    if (tmo_set) begin
      st_nxt.tmo_pend = 1'b1;
    end else if (rxq_rd) begin
      st_nxt.tmo_pend = 1'b0;
      st_nxt.tmo_cnt  = 10'h000;
    end else if (!st_r.tmo_pend && chan.rx_char_in) begin
      st_nxt.tmo_cnt = 10'h000;
    end else if (!rx_has) begin
      st_nxt.tmo_cnt = 10'h000;
    end else if (baud16_tick && st_r.tmo_cnt < tmo_limit) begin
      st_nxt.tmo_cnt = 10'(st_r.tmo_cnt + 10'h001);
    end

    // Line faults set, line status read clears; a new fault wins
    if (chan.line_fault) begin
      st_nxt.ls_pend = 1'b1;
    end else if (req.rd && hit(req, uci_pkg::OFS_LINE_ST)) begin
      st_nxt.ls_pend = 1'b0;
    end

    // Modem changes set, modem status read clears
    if (mdm_change) begin
      st_nxt.ms_pend = 1'b1;
    end else if (req.rd && hit(req, uci_pkg::OFS_MODEM_ST)) begin
      st_nxt.ms_pend = 1'b0;
    end

    // Transmit empty source; data write clears, id read only if it is what is reported
    if (txe_event) begin
      st_nxt.txe_pend = 1'b1;
    end else if (txq_wr
             || (iid_rd && code == uci_pkg::IID_TXE)) begin
      st_nxt.txe_pend = 1'b0;
    end

    // Transmit empty tracking
    unique case (st_r.tx_state)
      uci_pkg::TX_FILL: begin
        if (chan.tx_level >= uci_pkg::TX_MULTI) begin
          st_nxt.tx_multi = 1'b1;
        end
        if (tx_go_delay) begin
          st_nxt.tx_state = uci_pkg::TX_DELAY;
          st_nxt.tx_cnt   = 8'h00;
        end else if (tx_to_empty) begin
          st_nxt.tx_state = uci_pkg::TX_EMPTY;
          st_nxt.tx_immed = 1'b0;
        end
      end
      uci_pkg::TX_DELAY: begin
        if (chan.tx_level != 5'h00) begin
          st_nxt.tx_state = uci_pkg::TX_FILL;
          st_nxt.tx_multi = chan.tx_level >= uci_pkg::TX_MULTI;
        end else if (tx_to_empty) begin
          st_nxt.tx_state = uci_pkg::TX_EMPTY;
        end else if (baud16_tick) begin
          st_nxt.tx_cnt = 8'(st_r.tx_cnt + 8'h01);
        end
      end
      uci_pkg::TX_EMPTY: begin
        if (chan.tx_level != 5'h00) begin
          st_nxt.tx_state = uci_pkg::TX_FILL;
          st_nxt.tx_multi = chan.tx_level >= uci_pkg::TX_MULTI;
          st_nxt.tx_cnt   = 8'h00;
        end
      end
      default: begin
        st_nxt.tx_state = uci_pkg::TX_EMPTY;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.ien      <= uci_pkg::IEN_RST;
      st_r.fifo_en  <= uci_pkg::FIFO_RST;
      st_r.fmt      <= uci_pkg::FMT_RST;
      st_r.tx_state <= uci_pkg::TX_EMPTY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs; interrupt follows registered sources with no added delay
  assign rd_data                = st_r.rdata;
  assign fifo_enable_setting    = st_r.fifo_en;
  assign transmit_holding_empty = st_r.tx_state == uci_pkg::TX_EMPTY;
  assign channel_interrupt_out  = any_pend;

  //////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  irq_off_a: assert property (
    st_r.ien == 4'h0 |-> !channel_interrupt_out)
    else $error("interrupt high with all enables clear");

  iid_none_a: assert property (
    iid_rd && st_r.ien == 4'h0 |=> rd_data[3:0] == uci_pkg::IID_NONE)
    else $error("identification not suppressed");

  ien_upper_a: assert property (
    req.rd && hit(req, uci_pkg::OFS_IEN) |=> rd_data[7:4] == 4'h0)
    else $error("enable upper bits not zero");

  fifo_bits_a: assert property (
    iid_rd |=> rd_data[7:6] == ($past(st_r.fifo_en) ? 2'h3 : 2'h0)
               && rd_data[5:4] == 2'h0)
    else $error("identification upper bits wrong");

  line_prio_a: assert property (
    p_ls |-> channel_interrupt_out && code == uci_pkg::IID_LINE)
    else $error("line status not top priority");

  tmo_clear_a: assert property (
    rxq_rd && !tmo_set |=> !st_r.tmo_pend && st_r.tmo_cnt == 10'h000)
    else $error("time-out not cleared by buffer read");

  tmo_polled_a: assert property (
    $rose(st_r.tmo_pend) |-> $past(st_r.fifo_en && st_r.ien[0]))
    else $error("time-out raised in polled mode");

  txe_clear_a: assert property (
    txq_wr && !txe_event |=> !st_r.txe_pend)
    else $error("transmit empty not cleared by write");

  tx_delay_a: assert property (
    st_r.tx_state == uci_pkg::TX_DELAY && st_r.tx_cnt < tx_delay
    |=> st_r.tx_state != uci_pkg::TX_EMPTY)
    else $error("transmit empty indicated early");

  modem_a: assert property (
    mdm_change |=> st_r.ms_pend)
    else $error("modem change lost");

  pend_bit_a: assert property (
    iid_rd |=> rd_data[0] != $past(any_pend))
    else $error("pending bit does not match sources");

  tmo_bit_a: assert property (
    iid_rd && !st_r.fifo_en |=> !rd_data[3])
    else $error("time-out bit set without fifos");

  rx_level_a: assert property (
    st_r.fifo_en && st_r.ien[uci_pkg::IEN_RX] && !p_ls
    && chan.rx_level >= chan.rx_trigger |-> code == uci_pkg::IID_RXD)
    else $error("receive data not reported at trigger");

  tmo_fire_c: cover property (
    $rose(st_r.tmo_pend) ##[1:20] rxq_rd);
  tx_delay_c: cover property (
    st_r.tx_state == uci_pkg::TX_DELAY ##1
    st_r.tx_state == uci_pkg::TX_EMPTY);
  txe_iid_c: cover property (
    iid_rd && code == uci_pkg::IID_TXE ##1 !st_r.txe_pend);
  stack_c: cover property (
    p_ls && p_rx && p_txe);

endmodule : uci_top

/* hdl/uci_pkg.sv */
// Constants and types for one serial channel's interrupt logic.
// Assumes the channel's FIFOs and baud generator live outside this package.
package uci_pkg;

  // Register offsets on the channel's byte-wide register port
  localparam logic [2:0] OFS_DATA     = 3'h0;
  localparam logic [2:0] OFS_IEN      = 3'h1;
  localparam logic [2:0] OFS_IID      = 3'h2;
  localparam logic [2:0] OFS_CHAR_FMT = 3'h3;
  localparam logic [2:0] OFS_LINE_ST  = 3'h5;
  localparam logic [2:0] OFS_MODEM_ST = 3'h6;

  // Enable bit positions
  localparam int IEN_RX = 0;
  localparam int IEN_TX = 1;
  localparam int IEN_LS = 2;
  localparam int IEN_MS = 3;

  // Character format and fifo control field positions
  localparam int FMT_STOP = 2;
  localparam int FMT_PAR  = 3;
  localparam int FIFO_EN  = 0;

  // Identification codes, bits 3..0, and the fifo marker of bits 7..6
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_LINE = 4'h6;
  localparam logic [3:0] IID_RXD  = 4'h4;
  localparam logic [3:0] IID_TMO  = 4'hC;
  localparam logic [3:0] IID_TXE  = 4'h2;
  localparam logic [3:0] IID_MDM  = 4'h0;
  localparam logic [1:0] IID_FIFO = 2'h3;

  // Character timing in sixteen-times baud ticks
  localparam logic [3:0] START_BITS    = 4'h1;
  localparam logic [3:0] MIN_WORD      = 4'h5;
  localparam logic [7:0] TICKS_PER_BIT = 8'h10;
  localparam logic [9:0] TMO_CHARS     = 10'h004;
  localparam logic [4:0] TX_MULTI      = 5'h02;

  // Reset values
  localparam logic [3:0] IEN_RST  = 4'h0;
  localparam logic [3:0] FMT_RST  = 4'h0;
  localparam logic       FIFO_RST = 1'b0;

  // Transmit empty tracking
  typedef enum logic [2:0] {
    TX_FILL  = 3'b001,
    TX_DELAY = 3'b010,
    TX_EMPTY = 3'b100
  } uci_tx_e;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uci_req_s;

  // Status from the channel's fifos and receiver, same clock
  typedef struct packed {
    logic [4:0] rx_level;
    logic [4:0] rx_trigger;
    logic       rx_char_in;
    logic       line_fault;
    logic [4:0] tx_level;
  } uci_chan_s;

endpackage : uci_pkg

/* testbench/uci_chan_model.sv */
// Channel side model: receive fifo fill counter and 16x baud tick source.
// Assumes the bench pulses push and fault for one clock each.
`timescale 1ns/1ns
module uci_chan_model #(
  parameter int TICK_DIV = 2
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire uci_pkg::uci_req_s req,
  input  wire logic              push,
  input  wire logic              fault,
  input  wire logic [4:0]        tx_level,
  input  wire logic [4:0]        rx_trigger,
  output uci_pkg::uci_chan_s     chan,
  output logic                   baud16_tick
);
  logic [4:0] lvl_r;
  int         div_r;

  //////////////////////////////////////////////////////////////////////////
  // Fill follows pushes and host reads of the data offset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lvl_r <= 5'h00;
      div_r <= 0;
    end else begin
      div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
      if (push && lvl_r != 5'h10) begin
        lvl_r <= lvl_r + 5'h01;
      end else if (req.rd && req.addr == uci_pkg::OFS_DATA &&
                   lvl_r != 5'h00) begin
        lvl_r <= lvl_r - 5'h01;
      end
    end
  end

  // Tick every TICK_DIV clocks keeps the time-out run short
  assign baud16_tick = (div_r == TICK_DIV - 1);
  assign chan = '{rx_level: lvl_r, rx_trigger: rx_trigger,
                  rx_char_in: push, line_fault: fault, tx_level: tx_level};
endmodule : uci_chan_model

/* testbench/tb.sv */
// Self-checking bench for the channel interrupt logic.
// Assumes the channel model supplies fifo fill and baud ticks.
`timescale 1ns/1ns
module tb;
  logic              sys_clk = 1'b0;
  logic              resetn = 1'b0;
  uci_pkg::uci_req_s req = '0;
  logic              push = 1'b0;
  logic              fault = 1'b0;
  logic [4:0]        tx_level = 5'h01;
  logic [4:0]        rx_trigger = 5'h04;
  logic [3:0]        modem_pins = 4'h0;
  logic [7:0]        rd_data;
  uci_pkg::uci_chan_s chan;
  logic              baud16_tick;
  logic              fifo_enable_setting;
  logic              transmit_holding_empty;
  logic              channel_interrupt_out;
  int                miscompares = 0;
  int                checks_done = 0;
  logic [7:0]        d;
  logic [7:0]        v;

  always #10 sys_clk = ~sys_clk;

  uci_chan_model #(.TICK_DIV(2)) model (.sys_clk(sys_clk), .resetn(resetn),
    .req(req), .push(push), .fault(fault), .tx_level(tx_level),
    .rx_trigger(rx_trigger), .chan(chan), .baud16_tick(baud16_tick));

  uci_top dut (.sys_clk(sys_clk), .resetn(resetn), .req(req),
    .rd_data(rd_data), .chan(chan), .baud16_tick(baud16_tick),
    .modem_pins(modem_pins), .fifo_enable_setting(fifo_enable_setting),
    .transmit_holding_empty(transmit_holding_empty),
    .channel_interrupt_out(channel_interrupt_out));

  //////////////////////////////////////////////////////////////////////////
  // Expected identification byte
  function automatic logic [7:0] id(input logic f, input logic [3:0] c);
    return {f ? 2'h3 : 2'h0, 2'h0, c};
  endfunction : id

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic end_sim;
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // One-cycle strobes, changed just after the edge
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge sys_clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= w;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    q = rd_data;
  endtask : rd

  task automatic pulse(input logic sel);
    @(posedge sys_clk);
    if (sel) push <= 1'b1;
    else fault <= 1'b1;
    @(posedge sys_clk);
    push  <= 1'b0;
    fault <= 1'b0;
  endtask : pulse

  task automatic chk_id(input string n, input logic f, input logic [3:0] c);
    rd(uci_pkg::OFS_IID, d);
    chk(n, d, id(f, c));
  endtask : chk_id

  // Hang guard, well above the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    v = 8'($urandom(32'h453c));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(uci_pkg::OFS_IEN, d);
    chk("ien_rst", d, 8'h00);
    chk_id("iid_rst", 1'b0, uci_pkg::IID_NONE);
    chk("int_rst", {7'h0, channel_interrupt_out}, 8'h00);
    repeat (8) begin
      v = 8'($urandom);
      wr(uci_pkg::OFS_IEN, v);
      rd(uci_pkg::OFS_IEN, d);
      chk("ien_rw", d, {4'h0, v[3:0]});
    end
    // Line fault in non-fifo mode, cleared by line status read
    wr(uci_pkg::OFS_IEN, 8'h04);
    pulse(1'b0);
    chk_id("iid_line", 1'b0, uci_pkg::IID_LINE);
    chk("int_line", {7'h0, channel_interrupt_out}, 8'h01);
    rd(uci_pkg::OFS_LINE_ST, d);
    chk_id("iid_line_clr", 1'b0, uci_pkg::IID_NONE);
    // Fifo on: first transmit interrupt immediate, id read clears it
    wr(uci_pkg::OFS_IID, 8'h01);
    wr(uci_pkg::OFS_IEN, 8'h02);
    tx_level <= 5'h00;
    repeat (3) @(posedge sys_clk);
    chk("fifo_en", {7'h0, fifo_enable_setting}, 8'h01);
    chk_id("iid_tx_now", 1'b1, uci_pkg::IID_TXE);
    chk_id("iid_tx_clr", 1'b1, uci_pkg::IID_NONE);
    // One byte only: empty delayed by 96 ticks, 192 clocks
    tx_level <= 5'h01;
    repeat (4) @(posedge sys_clk);
    tx_level <= 5'h00;
    repeat (160) @(posedge sys_clk);
    chk_id("iid_tx_early", 1'b1, uci_pkg::IID_NONE);
    chk("empty_early", {7'h0, transmit_holding_empty}, 8'h00);
    repeat (70) @(posedge sys_clk);
    chk_id("iid_tx_late", 1'b1, uci_pkg::IID_TXE);
    chk("empty_late", {7'h0, transmit_holding_empty}, 8'h01);
    // Stack line, receive and transmit sources; peel them by priority
    wr(uci_pkg::OFS_DATA, 8'h5A);
    tx_level <= 5'h01;
    repeat (4) @(posedge sys_clk);
    tx_level <= 5'h00;
    repeat (250) @(posedge sys_clk);
    wr(uci_pkg::OFS_IEN, 8'h0F);
    repeat (4) pulse(1'b1);
    pulse(1'b0);
    chk_id("prio_line", 1'b1, uci_pkg::IID_LINE);
    rd(uci_pkg::OFS_LINE_ST, d);
    chk_id("prio_rx", 1'b1, uci_pkg::IID_RXD);
    rd(uci_pkg::OFS_DATA, d);
    chk_id("prio_tx", 1'b1, uci_pkg::IID_TXE);
    chk_id("prio_none", 1'b1, uci_pkg::IID_NONE);
    modem_pins <= 4'($urandom) | 4'h1;
    repeat (6) @(posedge sys_clk);
    chk_id("iid_modem", 1'b1, uci_pkg::IID_MDM);
    rd(uci_pkg::OFS_MODEM_ST, d);
    chk_id("modem_clr", 1'b1, uci_pkg::IID_NONE);
    repeat (3) rd(uci_pkg::OFS_DATA, d);
    // Time-out with two stop bits: 4 * 128 ticks = 1024 clocks
    wr(uci_pkg::OFS_CHAR_FMT, 8'h04);
    wr(uci_pkg::OFS_IEN, 8'h01);
    pulse(1'b1);
    repeat (600) @(posedge sys_clk);
    pulse(1'b1);
    repeat (600) @(posedge sys_clk);
    chk_id("tmo_restart", 1'b1, uci_pkg::IID_NONE);
    repeat (370) @(posedge sys_clk);
    chk_id("tmo_early", 1'b1, uci_pkg::IID_NONE);
    repeat (60) @(posedge sys_clk);
    chk_id("tmo_set", 1'b1, uci_pkg::IID_TMO);
    chk("int_tmo", {7'h0, channel_interrupt_out}, 8'h01);
    rd(uci_pkg::OFS_DATA, d);
    chk_id("tmo_clr", 1'b1, uci_pkg::IID_NONE);
    rd(uci_pkg::OFS_DATA, d);
    // All enables clear: no time-out, no id, output low
    wr(uci_pkg::OFS_IEN, 8'h00);
    pulse(1'b0);
    pulse(1'b1);
    repeat (1100) @(posedge sys_clk);
    chk_id("polled_id", 1'b1, uci_pkg::IID_NONE);
    chk("polled_int", {7'h0, channel_interrupt_out}, 8'h00);
    end_sim();
  end
endmodule : tb
